// file: verilog/watch_pkg.sv
// package: register map, field layout and constants of the watchdog timer
package watch_pkg;

    // ====================================================================
    // register map (byte addresses on the apb bus)
    localparam logic [11:0] ADDR_COUNTER = 12'h000;
    localparam logic [11:0] ADDR_CONTROL = 12'h004;

    // ====================================================================
    // access keys and strobe pattern of the only legal (16-bit) write
    localparam logic [7:0] KEY_COUNTER = 8'h5A;
    localparam logic [7:0] KEY_CONTROL = 8'hA5;
    localparam logic [3:0] STRB_HALF   = 4'h3;

    // ====================================================================
    // counter values
    localparam logic [7:0] COUNT_ZERO    = 8'h00;
    localparam logic [7:0] COUNT_ONE     = 8'h01;
    localparam logic [7:0] COUNT_TOP     = 8'hFF;
    localparam logic [7:0] COUNT_REENTER = 8'h80;
    localparam logic [7:0] COUNT_PRE_RE  = 8'h7F;

    // ====================================================================
    // count clock prescaler: eight taps, undivided down to divide by 4096
    localparam int          PRE_WIDTH = 12;
    localparam logic [11:0] PRE_ZERO  = 12'h000;
    localparam logic [11:0] PRE_ONE   = 12'h001;
    localparam logic [11:0] MASK_DIV1    = 12'h000;
    localparam logic [11:0] MASK_DIV4    = 12'h003;
    localparam logic [11:0] MASK_DIV16   = 12'h00F;
    localparam logic [11:0] MASK_DIV32   = 12'h01F;
    localparam logic [11:0] MASK_DIV64   = 12'h03F;
    localparam logic [11:0] MASK_DIV256  = 12'h0FF;
    localparam logic [11:0] MASK_DIV1024 = 12'h3FF;
    localparam logic [11:0] MASK_DIV4096 = 12'hFFF;

    // ====================================================================
    // wake pins: one non-maskable plus eight external interrupt pins
    localparam int         WAKE_PINS  = 9;
    localparam logic [8:0] WAKE_CLEAR = 9'h000;

    // ====================================================================
    // control/status register layout, bit 3 reserved and read as zero
    typedef struct packed {
        logic       timer_run_bit;
        logic       mode_select_bit;
        logic       watchdog_overflow_flag;
        logic       interval_overflow_flag;
        logic       reserved;
        logic [2:0] count_clock_select;
    } control_t;

    localparam control_t CONTROL_RESET = 8'h00;

    // ====================================================================
    // sequencing states, gray along idle-sleep-wake-after
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SLEEP  = 3'b001,
        ST_WAKE   = 3'b011,
        ST_AFTER  = 3'b010,
        ST_LOCKED = 3'b110,
        ST_FREQ   = 3'b100
    } state_t;

endpackage

// file: verilog/watchdog_interval_timer.sv
// watchdog / interval timer with keyed apb register access
`timescale 1ns/100ps

// Function
// (R1) 8-bit counter steps per selected tick; overflow: reset or interrupt.
// (R2) counter cleared by pin or debug reset, kept across own overflow reset.
// (R3) counter written only by 16-bit write with key 5A; bytes read it.
// (R4) control/status written only by 16-bit write with key A5.
// (R5) byte or longword writes to either register change nothing.
// (R6) control/status survives overflow reset, cleared by pin or debug reset.
// (R7) three-bit select picks one of eight clocks, divide 1 to 4096.
// (R8) mode bit 1 gives watchdog mode, 0 gives interval mode.
// (R9) normal counting only while run bit is 1.
// (R10) watchdog overflow sets its flag, requests chip reset, keeps counting.
// (R11) interval overflow sets its flag, requests interrupt, keeps counting.
// (R12) in standby, a level change on wake pins starts the count.
// (R13) standby-exit overflow restarts clocks without setting watchdog flag.
// (R14) after exit count on; standby bit set at 0x80 re-enters standby.
// (R15) pll write halts processor and counts; overflow resumes clocks.
// (R16) after the frequency-change overflow the counter stops at zero.
// (R17) a divider-only change does not involve the timer.
// (R18) software stops timer and loads select and count before such waits.
// (R19) software rewrites counter to zero periodically in watchdog mode.
// (R20) software checks counter is zero after a frequency change.
// (R21) standby ended by reset leaves timer idle; reset pin held until stable.
// (R22) interval mode: wrap right after writing FF is not an overflow.
// (R23) flags stay set until cleared by writing 0; writing 1 does nothing.
module watchdog_interval_timer
    import watch_pkg::*;
(
    // clock and reset
    input  wire logic                 MCLK_IN,
    input  wire logic                 RST_N_IN,
    input  wire logic                 DEBUG_RESET_IN,
    // apb slave
    input  wire logic                 PSEL_IN,
    input  wire logic                 PENABLE_IN,
    input  wire logic                 PWRITE_IN,
    input  wire logic [11:0]          PADDR_IN,
    input  wire logic [31:0]          PWDATA_IN,
    input  wire logic [3:0]           PSTRB_IN,
    output logic      [31:0]          PRDATA_OUT,
    output logic                      PREADY_OUT,
    output logic                      PSLVERR_OUT,
    // power control and clock generator side
    input  wire logic                 SOFT_STANDBY_IN,
    input  wire logic                 STANDBY_SELECT_IN,
    input  wire logic                 PLL_WRITE_IN,
    input  wire logic [WAKE_PINS-1:0] WAKE_PINS_IN,
    // requests out
    output logic                      CHIP_RESET_OUT,
    output logic                      INTERVAL_IRQ_OUT,
    output logic                      CLOCK_RESTART_OUT,
    output logic                      STANDBY_REENTER_OUT,
    output logic                      CPU_HALT_OUT
);

    // ====================================================================
    // prescaler tap decode
    function automatic logic tap_hit(input logic [2:0]  sel,
                                     input logic [11:0] pre);
        logic [11:0] mask;
        mask = MASK_DIV1;
        unique case (sel)
            3'h0: mask = MASK_DIV1;
            3'h1: mask = MASK_DIV4;
            3'h2: mask = MASK_DIV16;
            3'h3: mask = MASK_DIV32;
            3'h4: mask = MASK_DIV64;
            3'h5: mask = MASK_DIV256;
            3'h6: mask = MASK_DIV1024;
            3'h7: mask = MASK_DIV4096;
        endcase
        return (pre & mask) == PRE_ZERO;
    endfunction

    // ====================================================================
    // state
    state_t         state;
    state_t         next_state;

    control_t       control;
    control_t       next_control;

    logic [7:0]     count;
    logic [7:0]     next_count;

    logic [11:0]    prescale;
    logic [11:0]    next_prescale;

    logic           skip_wrap;
    logic           next_skip_wrap;

    logic [WAKE_PINS-1:0] pins_prev;

    logic           reset_pulse;
    logic           next_reset_pulse;

    logic           restart_pulse;
    logic           next_restart_pulse;

    logic           reenter_pulse;
    logic           next_reenter_pulse;

    logic [31:0]    rdata;
    logic [31:0]    next_rdata;

    logic           rerr;
    logic           next_rerr;

    // ====================================================================
    // bus decode
    logic setup;
    logic access;

    logic hit_counter;
    logic hit_control;
    logic half_write;
    logic counter_write;
    logic control_write;

    assign setup       = PSEL_IN && !PENABLE_IN;
    assign access      = PSEL_IN && PENABLE_IN && PWRITE_IN;
    assign hit_counter = PADDR_IN == ADDR_COUNTER;
    assign hit_control = PADDR_IN == ADDR_CONTROL;
    // only a 16-bit lane pattern can carry the key; others are dropped
    assign half_write  = access && PSTRB_IN == STRB_HALF;
    assign counter_write = half_write && hit_counter
                        && PWDATA_IN[15:8] == KEY_COUNTER;   // see (R3) (R5)
    assign control_write = half_write && hit_control
                        && PWDATA_IN[15:8] == KEY_CONTROL;   // see (R4) (R5)

    // ====================================================================
    // counting decode
    logic tick;
    logic counting;
    logic tick_en;
    logic wrap;
    logic overflow;
    logic wake_change;

    assign tick = tap_hit(control.count_clock_select, prescale);   // see (R7)
    // normal mode needs the run bit; wait states count regardless
    assign counting = (state == ST_IDLE && control.timer_run_bit)   // see (R9)
                   || state == ST_WAKE || state == ST_AFTER
                   || state == ST_FREQ;
    assign tick_en     = tick && counting;
    assign wrap        = tick_en && count == COUNT_TOP;
    assign overflow    = wrap && !counter_write && !skip_wrap;  // see (R22)
    assign wake_change = WAKE_PINS_IN != pins_prev;           // see (R12)

    // ====================================================================
    // next values
    always_comb begin
        next_state         = state;
        next_control       = control;
        next_count         = count;
        next_prescale      = prescale + PRE_ONE;
        next_skip_wrap     = skip_wrap;

        next_reset_pulse   = 1'b0;
        next_restart_pulse = 1'b0;
        next_reenter_pulse = 1'b0;

        next_rdata         = rdata;
        next_rerr          = rerr;

        // read data is captured in the setup phase: zero-wait answer
        if (setup) begin
            next_rerr  = !(hit_counter || hit_control);
            next_rdata = 32'h0000_0000;
            if (hit_counter) begin
                next_rdata[7:0] = count;                      // see (R3)
            end
            if (hit_control) begin
                next_rdata[7:0] = control;                    // see (R4)
            end
        end

        if (control_write) begin
            next_control.timer_run_bit      = PWDATA_IN[7];
            next_control.mode_select_bit    = PWDATA_IN[6];   // see (R8)
            next_control.count_clock_select = PWDATA_IN[2:0];
            // flags only clear on 0, a 1 leaves them alone
            next_control.watchdog_overflow_flag =
                control.watchdog_overflow_flag && PWDATA_IN[5]; // see (R23)
            next_control.interval_overflow_flag =
                control.interval_overflow_flag && PWDATA_IN[4]; // see (R23)
        end

        // a software write wins over a tick in the same cycle
        if (counter_write) begin
            next_count     = PWDATA_IN[7:0];                  // see (R3)
            next_skip_wrap = PWDATA_IN[7:0] == COUNT_TOP
                          && !control.mode_select_bit;        // see (R22)
        end else if (tick_en) begin
            next_count     = count + COUNT_ONE;               // see (R1)
            next_skip_wrap = 1'b0;
        end

        unique case (state)
            ST_IDLE: begin
                if (overflow && control.mode_select_bit) begin
                    // flag set wins over a clearing write in this cycle
                    next_control.watchdog_overflow_flag = 1'b1; // see (R10)
                    next_reset_pulse = 1'b1;                  // see (R10)
                end else if (overflow) begin
                    next_control.interval_overflow_flag = 1'b1; // see (R11)
                end
                // a divider-only change never arrives here
                if (PLL_WRITE_IN) begin
                    next_state = ST_FREQ;                  // see (R15) (R17)
                end else if (SOFT_STANDBY_IN) begin
                    next_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_change) begin
                    next_state = ST_WAKE;                     // see (R12)
                end else if (!SOFT_STANDBY_IN) begin
                    next_state = ST_IDLE;
                end
            end
            ST_WAKE: begin
                if (overflow) begin
                    next_restart_pulse = 1'b1;                // see (R13)
                    next_state = ST_AFTER;
                end
            end
            ST_AFTER: begin
                if (!STANDBY_SELECT_IN) begin
                    next_state = ST_IDLE;                     // see (R14)
                end else if (tick_en && !counter_write
                             && count == COUNT_PRE_RE) begin
                    next_reenter_pulse = 1'b1;                // see (R14)
                    next_state = ST_LOCKED;
                end
            end
            ST_LOCKED: begin
                // only a pin reset or a debug-port reset leaves this standby
                next_state = ST_LOCKED;
            end
            ST_FREQ: begin
                if (overflow) begin
                    next_restart_pulse = 1'b1;                // see (R15)
                    next_count = COUNT_ZERO;                  // see (R16)
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase

        // debug-port reset acts like the pin reset, one cycle later
        if (DEBUG_RESET_IN) begin
            next_state         = ST_IDLE;
            next_control       = CONTROL_RESET;               // see (R6)
            next_count         = COUNT_ZERO;                  // see (R2)
            next_prescale      = PRE_ZERO;
            next_skip_wrap     = 1'b0;
            next_reset_pulse   = 1'b0;
            next_restart_pulse = 1'b0;
            next_reenter_pulse = 1'b0;
        end
        next_control.reserved = 1'b0;
    end

    // ====================================================================
    // registers; the chip reset request does not feed back into them
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state         <= ST_IDLE;                         // see (R21)
            control       <= CONTROL_RESET;                   // see (R6)
            count         <= COUNT_ZERO;                      // see (R2)
            prescale      <= PRE_ZERO;
            skip_wrap     <= 1'b0;

            pins_prev     <= WAKE_CLEAR;
            reset_pulse   <= 1'b0;
            restart_pulse <= 1'b0;
            reenter_pulse <= 1'b0;

            rdata         <= 32'h0000_0000;
            rerr          <= 1'b0;
        end else begin
            state         <= next_state;
            control       <= next_control;
            count         <= next_count;
            prescale      <= next_prescale;
            skip_wrap     <= next_skip_wrap;

            pins_prev     <= WAKE_PINS_IN;
            reset_pulse   <= next_reset_pulse;
            restart_pulse <= next_restart_pulse;
            reenter_pulse <= next_reenter_pulse;

            rdata         <= next_rdata;
            rerr          <= next_rerr;
        end
    end

    // ====================================================================
    // outputs
    assign PRDATA_OUT          = rdata;
    assign PREADY_OUT          = 1'b1;
    assign PSLVERR_OUT         = PSEL_IN && PENABLE_IN && rerr;

    assign CHIP_RESET_OUT      = reset_pulse;
    assign INTERVAL_IRQ_OUT    = control.interval_overflow_flag;  // see (R11)
    assign CLOCK_RESTART_OUT   = restart_pulse;
    assign STANDBY_REENTER_OUT = reenter_pulse;
    assign CPU_HALT_OUT        = state == ST_FREQ;            // see (R15)

    // ====================================================================
    // assertions
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);

    a_keyed_count_write: assert property (          // see (R3)
        counter_write && !DEBUG_RESET_IN && state != ST_FREQ
        |=> count == $past(PWDATA_IN[7:0]))
        else $error("keyed counter write not stored");

    a_unkeyed_no_write: assert property (           // see (R5)
        access && hit_counter && !counter_write && !tick_en
        && !DEBUG_RESET_IN |=> $stable(count))
        else $error("unkeyed write changed the counter");

    a_stopped_no_count: assert property (           // see (R9)
        state == ST_IDLE && !control.timer_run_bit && !counter_write
        && !DEBUG_RESET_IN |=> $stable(count))
        else $error("counter moved with run bit clear");

    a_wdog_reset_req: assert property (             // see (R10)
        state == ST_IDLE && overflow && control.mode_select_bit
        && !DEBUG_RESET_IN
        |=> CHIP_RESET_OUT && control.watchdog_overflow_flag
        ##1 !CHIP_RESET_OUT)
        else $error("watchdog overflow reset wrong");

    a_interval_irq: assert property (               // see (R11)
        state == ST_IDLE && overflow && !control.mode_select_bit
        && !DEBUG_RESET_IN |=> INTERVAL_IRQ_OUT && !CHIP_RESET_OUT)
        else $error("interval overflow missed");

    a_wake_no_flag: assert property (               // see (R13)
        state == ST_WAKE && overflow && !DEBUG_RESET_IN
        |=> CLOCK_RESTART_OUT && state == ST_AFTER
        && !$rose(control.watchdog_overflow_flag))
        else $error("standby exit overflow wrong");

    a_freq_stop_zero: assert property (             // see (R16)
        state == ST_FREQ && overflow && !DEBUG_RESET_IN
        |=> count == COUNT_ZERO && !CPU_HALT_OUT && CLOCK_RESTART_OUT)
        else $error("frequency wait did not stop at zero");

    a_skip_first_wrap: assert property (            // see (R22)
        skip_wrap && wrap |=> !$rose(control.interval_overflow_flag))
        else $error("wrap after FF counted as overflow");

    a_flag_sticky: assert property (                // see (R23)
        control.watchdog_overflow_flag && !control_write
        && !DEBUG_RESET_IN |=> control.watchdog_overflow_flag)
        else $error("overflow flag dropped without write");

    a_reenter_at_80: assert property (              // see (R14)
        state == ST_AFTER && STANDBY_SELECT_IN && tick_en
        && !counter_write && count == COUNT_PRE_RE && !DEBUG_RESET_IN
        |=> STANDBY_REENTER_OUT && count == COUNT_REENTER)
        else $error("standby not re-entered at 80");

endmodule // watchdog_interval_timer

// file: testbench/testbench.sv
// self-checking testbench of the watchdog / interval timer
`timescale 1ns/100ps

module testbench;
    import watch_pkg::*;

    // ====================================================================
    // design ports
    logic                 mclk = 1'b0;
    logic                 rst_n = 1'b0;
    logic                 dbg_rst = 1'b0;
    logic                 psel = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite = 1'b0;
    logic [11:0]          paddr = 12'h000;
    logic [31:0]          pwdata = 32'h0000_0000;
    logic [3:0]           pstrb = 4'h0;
    logic                 soft_standby_select_bit = 1'b0;
    logic                 standby_select_bit_sel = 1'b0;
    logic                 pll_wr = 1'b0;
    logic [WAKE_PINS-1:0] wake = WAKE_CLEAR;
    logic [31:0]          prdata;
    logic                 pready, pslverr, chip_rst, irq;
    logic                 restart, reenter, halt;

    // ====================================================================
    // bench state: register model and pulse counters
    int                   n_errors = 0;
    int                   cmp_count = 0;
    int                   ev [4];
    int                   snap [4];
    int                   div [8] = '{1, 4, 16, 32, 64, 256, 1024, 4096};
    int                   idx;
    logic [7:0]           mdl_cnt, mdl_ctl, v, k;
    logic [3:0]           s;
    logic [31:0]          rd;
    logic                 err;

    watchdog_interval_timer u_watchdog_interval_timer (
        .MCLK_IN(mclk), .RST_N_IN(rst_n), .DEBUG_RESET_IN(dbg_rst),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .SOFT_STANDBY_IN(soft_standby_select_bit), .STANDBY_SELECT_IN(standby_select_bit_sel),
        .PLL_WRITE_IN(pll_wr), .WAKE_PINS_IN(wake),
        .CHIP_RESET_OUT(chip_rst), .INTERVAL_IRQ_OUT(irq),
        .CLOCK_RESTART_OUT(restart), .STANDBY_REENTER_OUT(reenter),
        .CPU_HALT_OUT(halt));

    initial begin
        forever #25 mclk = ~mclk;
    end

    // registered pulses are settled mid-cycle, so count them there
    always @(negedge mclk) begin
        if (chip_rst === 1'b1) ev[0]++;
        if (restart === 1'b1) ev[1]++;
        if (reenter === 1'b1) ev[2]++;
        if (irq === 1'b1) ev[3]++;
    end

    // ====================================================================
    // tasks
    task automatic end_of_test;
        $display("comparisons %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic check_range(input logic [7:0] got, input int lo, hi);
        cmp_count++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_errors++;
            $display("ERROR %0t: count %h out of range", $time, got);
        end
    endtask

    task automatic timeout(input string what);
        n_errors++;
        $display("ERROR %0t: no %s in time", $time, what);
        end_of_test();
    endtask

    // one apb transfer; the bench assumes no wait count, only a bound
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d, input logic [3:0] st);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= st;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) timeout("ready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] key, val,
                      input logic [3:0] st);
        apb(a, 1'b1, {16'h0000, key, val}, st);
        if (st === STRB_HALF && a === ADDR_COUNTER && key === KEY_COUNTER)
            mdl_cnt = val;
        if (st === STRB_HALF && a === ADDR_CONTROL && key === KEY_CONTROL)
            mdl_ctl = {val[7:6], val[5:4] & mdl_ctl[5:4], 1'b0, val[2:0]};
    endtask

    task automatic rdchk(input logic [11:0] a, input string what);
        apb(a, 1'b0, 32'h0000_0000, 4'h0);
        check(rd, {24'h00_0000, (a === ADDR_COUNTER) ? mdl_cnt : mdl_ctl},
              what);
        check(32'(err), 32'h0000_0000, "slave error");
    endtask

    task automatic wait_ev(input int sel, input int lim);
        int n;
        n = 0;
        while (ev[sel] == snap[sel] && n < lim) begin
            @(posedge mclk);
            n++;
        end
        if (ev[sel] == snap[sel]) timeout("event");
        cmp_count++;
    endtask

    // ====================================================================
    // main sequence
    initial begin
        void'($urandom(32'h3047));
        mdl_cnt = COUNT_ZERO;
        mdl_ctl = CONTROL_RESET;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        rdchk(ADDR_COUNTER, "counter reset");
        rdchk(ADDR_CONTROL, "control reset");
        for (int i = 0; i < 6; i++) begin
            v = 8'($urandom);
            k = 8'($urandom);
            s = 4'($urandom);
            if (k === KEY_COUNTER) k = ~k;
            if (s === STRB_HALF) s = 4'hF;
            wr(ADDR_COUNTER, KEY_COUNTER, v, STRB_HALF);
            rdchk(ADDR_COUNTER, "keyed counter");
            wr(ADDR_COUNTER, k, ~v, STRB_HALF);
            rdchk(ADDR_COUNTER, "wrong key");
            wr(ADDR_COUNTER, KEY_COUNTER, ~v, s);
            rdchk(ADDR_COUNTER, "counter width");
            wr(ADDR_CONTROL, KEY_CONTROL, v & 8'h4F, STRB_HALF);
            rdchk(ADDR_CONTROL, "keyed control");
            wr(ADDR_CONTROL, KEY_CONTROL, ~v & 8'h4F, s);
            wr(ADDR_CONTROL, ~k, ~v & 8'h4F, STRB_HALF);
            rdchk(ADDR_CONTROL, "control width");
        end
        apb(12'h008, 1'b1, 32'h0000_A5FF, STRB_HALF);
        check(32'(err), 32'h0000_0001, "unmapped write");
        apb(12'h008, 1'b0, 32'h0000_0000, 4'h0);
        check(rd, 32'h0000_0000, "unmapped read");
        // count rate per select code; the tolerance covers bus overhead
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_CONTROL, KEY_CONTROL, 8'h00, STRB_HALF);
            wr(ADDR_COUNTER, KEY_COUNTER, COUNT_ZERO, STRB_HALF);
            wr(ADDR_CONTROL, KEY_CONTROL, 8'(8'h80 | c), STRB_HALF);
            repeat (4 * div[c]) @(posedge mclk);
            apb(ADDR_COUNTER, 1'b0, 32'h0000_0000, 4'h0);
            check_range(rd[7:0], 4, 7);
        end
        wr(ADDR_CONTROL, KEY_CONTROL, 8'h00, STRB_HALF);
        wr(ADDR_COUNTER, KEY_COUNTER, 8'h37, STRB_HALF);
        repeat (20) @(posedge mclk);
        rdchk(ADDR_COUNTER, "stopped");
        // interval overflow, flag clearing by zero only
        wr(ADDR_COUNTER, KEY_COUNTER, 8'hFD, STRB_HALF);
        snap = ev;
        wr(ADDR_CONTROL, KEY_CONTROL, 8'h80, STRB_HALF);
        wait_ev(3, 20);
        mdl_ctl = 8'h90;
        rdchk(ADDR_CONTROL, "interval flag");
        wr(ADDR_CONTROL, KEY_CONTROL, 8'h80, STRB_HALF);
        rdchk(ADDR_CONTROL, "flag clear");
        wr(ADDR_CONTROL, KEY_CONTROL, 8'h90, STRB_HALF);
        rdchk(ADDR_CONTROL, "flag write one");
        check(32'(irq), 32'h0000_0000, "irq low");
        wr(ADDR_CONTROL, KEY_CONTROL, 8'h00, STRB_HALF);
        wr(ADDR_COUNTER, KEY_COUNTER, COUNT_TOP, STRB_HALF);
        snap = ev;
        wr(ADDR_CONTROL, KEY_CONTROL, 8'h80, STRB_HALF);
        repeat (200) @(posedge mclk);
        check(32'(ev[3] - snap[3]), 32'h0000_0000, "top wrap");
        wait_ev(3, 100);
        // watchdog mode: periodic rewrite, then overflow
        wr(ADDR_CONTROL, KEY_CONTROL, 8'h40, STRB_HALF);
        wr(ADDR_COUNTER, KEY_COUNTER, COUNT_ZERO, STRB_HALF);
        snap = ev;
        wr(ADDR_CONTROL, KEY_CONTROL, 8'hC0, STRB_HALF);
        repeat (5) begin
            repeat (150) @(posedge mclk);
            wr(ADDR_COUNTER, KEY_COUNTER, COUNT_ZERO, STRB_HALF);
        end
        check(32'(ev[0] - snap[0]), 32'h0000_0000, "kicked");
        wr(ADDR_COUNTER, KEY_COUNTER, 8'hFD, STRB_HALF);
        wait_ev(0, 20);
        mdl_ctl = 8'hE0;
        rdchk(ADDR_CONTROL, "watchdog flag");
        @(posedge mclk);
        dbg_rst <= 1'b1;
        @(posedge mclk);
        dbg_rst <= 1'b0;
        mdl_cnt = COUNT_ZERO;
        mdl_ctl = CONTROL_RESET;
        rdchk(ADDR_COUNTER, "debug reset");
        rdchk(ADDR_CONTROL, "debug reset");
        // frequency change wait
        wr(ADDR_COUNTER, KEY_COUNTER, 8'hF0, STRB_HALF);
        snap = ev;
        @(posedge mclk);
        pll_wr <= 1'b1;
        @(posedge mclk);
        pll_wr <= 1'b0;
        @(negedge mclk);
        check(32'(halt), 32'h0000_0001, "halt");
        wait_ev(1, 40);
        @(negedge mclk);
        check(32'(halt), 32'h0000_0000, "resume");
        repeat (20) @(posedge mclk);
        mdl_cnt = COUNT_ZERO;
        rdchk(ADDR_COUNTER, "held zero");
        rdchk(ADDR_CONTROL, "no flag");
        // standby exit, then re-entry with standby still selected
        wr(ADDR_COUNTER, KEY_COUNTER, 8'hF0, STRB_HALF);
        @(posedge mclk);
        soft_standby_select_bit <= 1'b1;
        standby_select_bit_sel <= 1'b1;
        repeat (10) @(posedge mclk);
        rdchk(ADDR_COUNTER, "no wake");
        snap = ev;
        idx = $urandom % WAKE_PINS;
        wake[idx] <= ~wake[idx];
        wait_ev(1, 40);
        soft_standby_select_bit <= 1'b0;
        rdchk(ADDR_CONTROL, "exit no flag");
        wait_ev(2, 160);
        @(posedge mclk);
        rst_n <= 1'b0;
        standby_select_bit_sel <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        mdl_cnt = COUNT_ZERO;
        rdchk(ADDR_COUNTER, "pin reset");
        rdchk(ADDR_CONTROL, "pin reset");
        end_of_test();
    end

endmodule // testbench
